// *** hdl/icc_pkg.sv ***
// package for the interrupt control configuration block
// assumes a 32-bit apb register bus on a single 40 MHz clock
package icc_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [11:0] ICC_OFS_CONTROL = 12'h000;
  localparam logic [11:0] ICC_OFS_STATUS  = 12'h004;
  localparam logic [11:0] ICC_OFS_MASK    = 12'h008;
  localparam logic [11:0] ICC_OFS_PEND    = 12'h00C;

  // ------------------------------------------------------------
  // field layout of the control word
  // ------------------------------------------------------------
  localparam int          ICC_NUM_EXT       = 5;
  localparam int          ICC_POS_VEC_MODE  = 12;
  localparam int          ICC_POS_THR_LO    = 8;
  localparam int          ICC_THR_W         = 3;
  localparam int          ICC_POS_EDGE_LO   = 0;
  localparam logic [31:0] ICC_CONTROL_WMASK = 32'h0000171F;
  localparam logic [31:0] ICC_CONTROL_RESET = 32'h00000000;
  localparam logic [2:0]  ICC_THR_OFF       = 3'h0;

  // ------------------------------------------------------------
  // status layout: bits 4:0 edges seen, bit 5 proximity start
  // ------------------------------------------------------------
  localparam int          ICC_NUM_EVT       = 6;
  localparam int          ICC_POS_EVT_PROX  = 5;
  localparam logic [5:0]  ICC_EVT_RESET     = 6'h00;

  // decoded view of the control word
  typedef struct packed {
    logic                    vector_mode_select;
    logic [ICC_THR_W-1:0]    proximity_priority_threshold;
    logic [ICC_NUM_EXT-1:0]  edge_select;
  } icc_cfg_t;

endpackage : icc_pkg

// *** hdl/icc_edge_det.sv ***
// one synchronised edge detector per external interrupt pin
// assumes asynchronous pins; polarity comes from same-clock logic
`timescale 1ns/1ps
module icc_edge_det #(
  parameter int N = 5
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // pins and polarity
  input  wire logic [N-1:0] pin_in,
  input  wire logic [N-1:0] rising_sel,
  // one-cycle edge pulses
  output logic      [N-1:0] edge_pulse
);

  // ------------------------------------------------------------
  // per-pin synchroniser and detector
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_pin
      logic meta_reg;
      logic sync_reg;
      logic last_reg;
      wire  rise_w = sync_reg & ~last_reg;
      wire  fall_w = ~sync_reg & last_reg;
      // only sync_reg reads meta_reg
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
          last_reg <= 1'b0;
        end else begin
          meta_reg <= pin_in[g];
          sync_reg <= meta_reg;
          last_reg <= sync_reg;
        end
      end
      // selected edge only
      assign edge_pulse[g] = rising_sel[g] ? rise_w : fall_w;
    end
  endgenerate

endmodule : icc_edge_det

// *** hdl/icc_prox_start.sv ***
// decides whether an interrupt's group priority starts the proximity timer
// assumes priority and request come from same-clock logic
`timescale 1ns/1ps
module icc_prox_start (
  // threshold and request
  input  wire logic [2:0] threshold,
  input  wire logic [2:0] group_prio,
  input  wire logic       irq_valid,
  // decision
  output logic            start
);

  // ------------------------------------------------------------
  // compare
  // ------------------------------------------------------------
  wire enabled_w = (threshold != icc_pkg::ICC_THR_OFF);
  wire in_range_w = (group_prio <= threshold);

  // zero threshold never starts the timer
  assign start = irq_valid & enabled_w & in_range_w;

endmodule : icc_prox_start

// *** hdl/icc_top.sv ***
// Functional notes
// - bit 12 chooses multi or single vector
// - threshold 1-7: priority at or below starts timer
// - threshold zero disables the proximity timer
// - bits 4:0 pick rising or falling edge
// - unimplemented control bits read zero, ignore writes
//
// interrupt control configuration: apb slave, edge detect, proximity start
// assumes an apb master on pclk; pins are asynchronous to pclk
`timescale 1ns/1ps
module icc_top #(
  parameter int NUM_EXT = icc_pkg::ICC_NUM_EXT
) (
  // apb clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  input  wire logic [3:0]         pstrb,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // external interrupt pins
  input  wire logic [NUM_EXT-1:0] ext_irq_pin,
  // interrupt in service from the controller
  input  wire logic               irq_valid,
  input  wire logic [2:0]         irq_group_prio,
  // configuration toward the controller
  output logic                    vector_mode_select,
  output logic [2:0]              proximity_priority_threshold,
  output logic [NUM_EXT-1:0]      ext_irq_pending,
  output logic                    prox_timer_start,
  // interrupt line
  output logic                    irq
);

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [31:0]                      control_reg;
  logic [icc_pkg::ICC_NUM_EVT-1:0]  status_reg;
  logic [icc_pkg::ICC_NUM_EVT-1:0]  mask_reg;
  logic [NUM_EXT-1:0]               pend_reg;
  logic [31:0]                      prdata_reg;
  logic                             pready_reg;
  logic                             pslverr_reg;
  logic                             vec_reg;
  logic [2:0]                       thr_reg;
  logic                             prox_reg;
  logic                             irq_reg;
  icc_pkg::icc_cfg_t                cfg;

  // ------------------------------------------------------------
  // decode of the control word
  // ------------------------------------------------------------
  assign cfg.vector_mode_select = control_reg[icc_pkg::ICC_POS_VEC_MODE];
  assign cfg.proximity_priority_threshold =
    control_reg[icc_pkg::ICC_POS_THR_LO +: icc_pkg::ICC_THR_W];
  assign cfg.edge_select = control_reg[icc_pkg::ICC_POS_EDGE_LO +: icc_pkg::ICC_NUM_EXT];

  // ------------------------------------------------------------
  // edge detectors and proximity decision
  // ------------------------------------------------------------
  logic [NUM_EXT-1:0] edge_pulse;
  logic               prox_start;

  icc_edge_det #(
    .N (NUM_EXT)
  ) u_edge (
    .pclk       (pclk),
    .presetn    (presetn),
    .pin_in     (ext_irq_pin),
    .rising_sel (cfg.edge_select[NUM_EXT-1:0]),
    .edge_pulse (edge_pulse)
  );

  icc_prox_start u_prox (
    .threshold  (cfg.proximity_priority_threshold),
    .group_prio (irq_group_prio),
    .irq_valid  (irq_valid),
    .start      (prox_start)
  );

  // ------------------------------------------------------------
  // apb decode: zero wait states, every access completes at once
  // ------------------------------------------------------------
  wire setup_w   = psel & ~penable;
  wire access_w  = psel & penable & pready_reg;
  wire wr_w      = access_w & pwrite;
  wire hit_ctl_w = (paddr == icc_pkg::ICC_OFS_CONTROL);
  wire hit_sts_w = (paddr == icc_pkg::ICC_OFS_STATUS);
  wire hit_msk_w = (paddr == icc_pkg::ICC_OFS_MASK);
  wire hit_pnd_w = (paddr == icc_pkg::ICC_OFS_PEND);
  wire mapped_w  = hit_ctl_w | hit_sts_w | hit_msk_w | hit_pnd_w;

  // byte strobes expanded to a bit mask
  wire [31:0] strb_mask_w = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  wire [31:0] ctl_wmask_w = strb_mask_w & icc_pkg::ICC_CONTROL_WMASK;
  wire [31:0] control_next = (control_reg & ~ctl_wmask_w) | (pwdata & ctl_wmask_w);

  // read mux; unused bits read as zero
  wire [31:0] rd_mux_w =
    hit_ctl_w ? (control_reg & icc_pkg::ICC_CONTROL_WMASK) :
    hit_sts_w ? {26'h0000000, status_reg} :
    hit_msk_w ? {26'h0000000, mask_reg} :
    hit_pnd_w ? {{(32-NUM_EXT){1'b0}}, pend_reg} : 32'h00000000;

  // ------------------------------------------------------------
  // event and pending next values; a new event beats a clear
  // ------------------------------------------------------------
  wire [icc_pkg::ICC_NUM_EVT-1:0] evt_w   = {prox_start, edge_pulse};
  wire [icc_pkg::ICC_NUM_EVT-1:0] sclr_w  =
    (wr_w & hit_sts_w & pstrb[0]) ? pwdata[icc_pkg::ICC_NUM_EVT-1:0] : 6'h00;
  wire [icc_pkg::ICC_NUM_EVT-1:0] status_next = (status_reg & ~sclr_w) | evt_w;
  wire [NUM_EXT-1:0] pclr_w =
    (wr_w & hit_pnd_w & pstrb[0]) ? pwdata[NUM_EXT-1:0] : {NUM_EXT{1'b0}};
  wire [NUM_EXT-1:0] pend_next = (pend_reg & ~pclr_w) | edge_pulse;
  wire irq_next = |(status_next & mask_reg);

  // ------------------------------------------------------------
  // control register
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_reg <= icc_pkg::ICC_CONTROL_RESET;
    end else if (wr_w && hit_ctl_w) begin
      control_reg <= control_next;
    end
  end

  // mask register, low byte lane only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= icc_pkg::ICC_EVT_RESET;
    end else if (wr_w && hit_msk_w && pstrb[0]) begin
      mask_reg <= pwdata[icc_pkg::ICC_NUM_EVT-1:0];
    end
  end

  // ------------------------------------------------------------
  // sticky status and pending requests
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= icc_pkg::ICC_EVT_RESET;
      pend_reg   <= {NUM_EXT{1'b0}};
      irq_reg    <= 1'b0;
    end else begin
      status_reg <= status_next;
      pend_reg   <= pend_next;
      irq_reg    <= irq_next;
    end
  end

  // ------------------------------------------------------------
  // registered outputs toward the controller
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vec_reg  <= 1'b0;
      thr_reg  <= icc_pkg::ICC_THR_OFF;
      prox_reg <= 1'b0;
    end else begin
      vec_reg  <= control_next[icc_pkg::ICC_POS_VEC_MODE] & wr_w & hit_ctl_w
                  | cfg.vector_mode_select & ~(wr_w & hit_ctl_w);
      thr_reg  <= (wr_w && hit_ctl_w) ?
                  control_next[icc_pkg::ICC_POS_THR_LO +: icc_pkg::ICC_THR_W] :
                  cfg.proximity_priority_threshold;
      prox_reg <= prox_start;
    end
  end

  // ------------------------------------------------------------
  // apb answer: pready rises in the access cycle after setup
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h00000000;
    end else begin
      pready_reg  <= setup_w;
      pslverr_reg <= setup_w & ~mapped_w;
      prdata_reg  <= (setup_w && !pwrite) ? rd_mux_w : 32'h00000000;
    end
  end

  assign prdata                       = prdata_reg;
  assign pready                       = pready_reg;
  assign pslverr                      = pslverr_reg;
  assign vector_mode_select           = vec_reg;
  assign proximity_priority_threshold = thr_reg;
  assign ext_irq_pending              = pend_reg;
  assign prox_timer_start             = prox_reg;
  assign irq                          = irq_reg;

endmodule : icc_top

// *** verification/icc_top_properties.sv ***
// concurrent checks on the ports of the interrupt control configuration block
// assumes one pclk domain with presetn asynchronous active low
`timescale 1ns/1ps
module icc_top_properties #(
  parameter int NUM_EXT = 5
) (
  // clock and reset
  input wire logic               pclk,
  input wire logic               presetn,
  // apb
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [11:0]        paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [31:0]        prdata,
  input wire logic [3:0]         pstrb,
  input wire logic               pready,
  input wire logic               pslverr,
  // controller side
  input wire logic               irq_valid,
  input wire logic               vector_mode_select,
  input wire logic               prox_timer_start,
  input wire logic [2:0]         irq_group_prio,
  input wire logic [2:0]         proximity_priority_threshold,
  input wire logic [NUM_EXT-1:0] ext_irq_pending
);
  // --------------------------------------------------------------
  // bus phases
  // --------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_acc; psel && penable && pready; endsequence
  // control write commit; lane 1 carries every writable field but the edges
  wire ctl_wr = psel && penable && pready && pwrite && paddr == icc_pkg::ICC_OFS_CONTROL;

  chk_ready_one: assert property (s_setup |=> pready)
    else $error("no answer in the cycle after setup");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  chk_vec_write: assert property (
    ctl_wr && pstrb[1] |=> vector_mode_select == $past(pwdata[12]))
    else $error("vector mode did not follow the write");
  chk_thr_write: assert property (
    ctl_wr && pstrb[1] |=> proximity_priority_threshold == $past(pwdata[10:8]))
    else $error("threshold did not follow the write");
  chk_prox_start: assert property (
    irq_valid && proximity_priority_threshold != 3'h0
    && irq_group_prio <= proximity_priority_threshold |=> prox_timer_start)
    else $error("qualifying priority did not start the timer");
  chk_prox_off: assert property (proximity_priority_threshold == 3'h0 |=> !prox_timer_start)
    else $error("timer started while disabled");
  chk_ctrl_zero: assert property (
    s_acc ##0 (!pwrite && paddr == icc_pkg::ICC_OFS_CONTROL)
    |-> (prdata & ~icc_pkg::ICC_CONTROL_WMASK) == 32'h00000000)
    else $error("unimplemented control bit read as one");
  chk_unmapped_err: assert property (s_acc ##0 (paddr > 12'h00C) |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_pend_sticky: assert property (
    |($past(ext_irq_pending) & ~ext_irq_pending)
    |-> $past(psel && penable && pwrite && paddr == icc_pkg::ICC_OFS_PEND))
    else $error("pending bit fell without a clear write");
endmodule : icc_top_properties

bind icc_top icc_top_properties #(.NUM_EXT(NUM_EXT)) icc_top_properties_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pstrb(pstrb), .pready(pready),
  .pslverr(pslverr), .irq_valid(irq_valid), .vector_mode_select(vector_mode_select),
  .prox_timer_start(prox_timer_start), .irq_group_prio(irq_group_prio),
  .proximity_priority_threshold(proximity_priority_threshold),
  .ext_irq_pending(ext_irq_pending));

// *** verification/icc_far_model.sv ***
// far side: external interrupt pins and the in-service request of the controller
// assumes the bench calls its tasks; levels change just after a rising edge
`timescale 1ns/1ps
module icc_far_model (
  // clock
  input  wire logic pclk,
  // pins and request
  output logic [4:0] pin,
  output logic       valid,
  output logic [2:0] prio
);
  // pins rest low so the first edge seen is a deliberate one
  initial begin
    pin   = 5'h00;
    valid = 1'b0;
    prio  = 3'h0;
  end
  task set_pins(input logic [4:0] v);
    @(posedge pclk);
    pin <= v;
  endtask : set_pins
  task request(input logic on, input logic [2:0] p);
    @(posedge pclk);
    valid <= on;
    prio  <= p;
  endtask : request
endmodule : icc_far_model

// *** verification/test_interrupt_control_config.sv ***
// self-checking bench for the interrupt control configuration block
// assumes apb access that polls pready for the answer, with no fixed wait, and a far-side model
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %s expected %0h seen %0h", n, e, g); end end
module test_interrupt_control_config;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic        irq_valid, vms, pst, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  thr, prio;
  logic [4:0]  pins, pend;
  int          errors = 0, checked = 0, cyc = 0;

  icc_top icc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_irq_pin(pins), .irq_valid(irq_valid),
    .irq_group_prio(prio), .vector_mode_select(vms), .proximity_priority_threshold(thr),
    .ext_irq_pending(pend), .prox_timer_start(pst), .irq(irq));
  icc_far_model icc_far_model_inst (.pclk(pclk), .pin(pins), .valid(irq_valid), .prio(prio));

  // --------------------------------------------------------------
  // bus tasks: answer is taken at the rising edge where pready is sampled high
  // --------------------------------------------------------------
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no fixed wait assumed; only the runaway guard ends a hung access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rchk(input string n, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(n, e, rd)
  endtask : rchk
  task settle(input int k);
    repeat (k) @(posedge pclk);
    @(negedge pclk);
  endtask : settle

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task t_regs;
    for (int a = 0; a < 16; a += 4) rchk("reset value", 12'(a), 32'h0);
    apb(1'b1, 12'h000, 32'hFFFFFFFF);
    rchk("control mask", 12'h000, 32'h0000171F);
    `CHK("mapped err", 1'b0, er)
    `CHK("vector multi", 1'b1, vms)
    `CHK("threshold", 3'h7, thr)
    apb(1'b1, 12'h000, 32'h0);
    // the write lands on the edge the task returns at; look half a cycle on
    settle(0);
    `CHK("vector single", 1'b0, vms)
    apb(1'b0, 12'h010, 32'h0);
    `CHK("unmapped err", 1'b1, er)
    `CHK("unmapped data", 32'h0, rd)
  endtask : t_regs
  // every threshold against every priority, zero included
  task t_prox;
    for (int t = 0; t < 8; t++) begin
      apb(1'b1, 12'h000, 32'(t) << 8);
      for (int p = 0; p < 8; p++) begin
        icc_far_model_inst.request(1'b1, 3'(p));
        settle(1);
        `CHK("prox start", (t != 0 && p <= t), pst)
      end
    end
    icc_far_model_inst.request(1'b0, 3'h0);
    rchk("prox status", 12'h004, 32'h20);
    apb(1'b1, 12'h004, 32'h3F);
  endtask : t_prox
  // each polarity must catch its own edge and ignore the other one
  task t_edge;
    apb(1'b1, 12'h000, 32'h1F);
    icc_far_model_inst.set_pins(5'h1F);
    settle(6);
    `CHK("rise seen", 5'h1F, pend)
    `CHK("irq masked", 1'b0, irq)
    apb(1'b1, 12'h00C, 32'h1F);
    icc_far_model_inst.set_pins(5'h00);
    settle(6);
    `CHK("fall ignored", 5'h00, pend)
    apb(1'b1, 12'h000, 32'h0);
    icc_far_model_inst.set_pins(5'h1F);
    settle(6);
    `CHK("rise ignored", 5'h00, pend)
    icc_far_model_inst.set_pins(5'h00);
    settle(6);
    `CHK("fall seen", 5'h1F, pend)
    rchk("status", 12'h004, 32'h1F);
    apb(1'b1, 12'h008, 32'h1F);
    settle(1);
    `CHK("irq raised", 1'b1, irq)
    apb(1'b1, 12'h004, 32'h1F);
    settle(1);
    `CHK("irq cleared", 1'b0, irq)
  endtask : t_edge

  task wrap_up;
    if (errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  // clock, then reset held for two cycles
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // runaway guard well above the little over two hundred cycles the scenarios need
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin errors++; wrap_up(); end
  end
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0; pwdata = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_prox();
    t_edge();
    wrap_up();
  end
endmodule : test_interrupt_control_config
